// [rtl/ppt_defs.vh]
// Constants for the two-timer PWM and pulse block
`ifndef PPT_DEFS_VH
`define PPT_DEFS_VH
// Register indices; the byte address is four times the index
`define PPT_IDX_T1_CTRL   8'h50
`define PPT_IDX_T1_DUTY   8'h51
`define PPT_IDX_T2_CTRL   8'h52
`define PPT_IDX_T2_DUTY   8'h53
`define PPT_IDX_ENABLE    8'h58
`define PPT_IDX_STATUS    8'h59
`define PPT_ADDR_W        12
// Register select codes
`define PPT_SEL_T1_CTRL   3'h0
`define PPT_SEL_T1_DUTY   3'h1
`define PPT_SEL_T2_CTRL   3'h2
`define PPT_SEL_T2_DUTY   3'h3
`define PPT_SEL_ENABLE    3'h4
`define PPT_SEL_STATUS    3'h5
`define PPT_SEL_NONE      3'h7
// Field layout
`define PPT_PC_HI         5
`define PPT_PC_LO         2
`define PPT_MC1_BIT       0
`define PPT_MC2_HI        1
`define PPT_MC2_LO        0
`define PPT_T1_CTRL_MASK  8'h3d
`define PPT_T2_CTRL_MASK  8'h3f
`define PPT_EN_MASTER     0
`define PPT_EN_SECOND     1
// Reset values
`define PPT_CTRL_RST      8'h00
`define PPT_DUTY_RST      8'h00
`define PPT_EN_RST        2'h0
// Timer modes
`define PPT_MODE_PWM      2'h0
`define PPT_MODE_PULSE    2'h1
`define PPT_MODE_SYNC     2'h2
`define PPT_MODE_FOLLOW   2'h3
// Timing
`define PPT_CLK_MHZ       40
`define PPT_BASE_US       100
`define PPT_US_PER_MS     1000
`define PPT_US_PER_S      1000000
`define PPT_PER_C0_MS     4
`define PPT_PER_C1_MS     8
`define PPT_PER_C2_MS     20
`define PPT_PER_C3_MS     30
`define PPT_PER_C4_MS     50
`define PPT_PER_C5_MS     100
`define PPT_PER_C6_MS     200
`define PPT_PER_C7_MS     400
`define PPT_PER_C8_MS     800
`define PPT_PER_C9_S      1
`define PPT_PER_C10_S     2
`define PPT_PER_C11_S     4
`define PPT_DUTY_FULL     24'h0000ff
`define PPT_CNT_MAX       16'hffff
// AXI responses
`define PPT_RESP_OKAY     2'h0
`define PPT_RESP_SLVERR   2'h2
`endif

// [rtl/ppt_timer.v]
// One PWM or pulse timer channel
`timescale 1ns/100ps
`default_nettype none
`include "ppt_defs.vh"
module ppt_timer (
  // Clock and control
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       tick_i,
  input  wire       enable_i,
  // Settings
  input  wire [1:0] mode_i,
  input  wire [3:0] period_code_i,
  input  wire [7:0] duty_i,
  // Triggers from the master
  input  wire       trig_start_i,
  input  wire       trig_end_i,
  // Output and events
  output reg        out_o,
  output reg        start_o,
  output reg        end_o
);

  // Period length in base ticks
  function [15:0] period_ticks;
    input [3:0] code;
    reg [31:0] t;
    begin
      case (code) // [RULE_01]
        4'h0: t = `PPT_PER_C0_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h1: t = `PPT_PER_C1_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h2: t = `PPT_PER_C2_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h3: t = `PPT_PER_C3_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h4: t = `PPT_PER_C4_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h5: t = `PPT_PER_C5_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h6: t = `PPT_PER_C6_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h7: t = `PPT_PER_C7_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h8: t = `PPT_PER_C8_MS * `PPT_US_PER_MS / `PPT_BASE_US;
        4'h9: t = `PPT_PER_C9_S * `PPT_US_PER_S / `PPT_BASE_US;
        4'ha: t = `PPT_PER_C10_S * `PPT_US_PER_S / `PPT_BASE_US;
        default: t = `PPT_PER_C11_S * `PPT_US_PER_S / `PPT_BASE_US; // [RULE_15]
      endcase
      period_ticks = t[15:0];
    end
  endfunction

  reg  [15:0] count;
  reg         en_q;
  reg         armed;
  reg         active;
  reg         raw_q;
  reg         raw;

  wire [15:0] period = period_ticks(period_code_i);
  wire        slave  = mode_i[1];
  // Multiply instead of divide: count*255 < duty*period
  wire [23:0] lim_w  = {16'h0000, duty_i} * {8'h00, period};
  wire [23:0] pos_w  = {8'h00, count} * `PPT_DUTY_FULL;
  wire        wrap   = ~slave & tick_i & (count >= period - 16'h0001); // [RULE_16]
  wire        rise   = enable_i & ~en_q;
  wire        trig   = ((mode_i == `PPT_MODE_SYNC) & trig_start_i) |
                       ((mode_i == `PPT_MODE_FOLLOW) & trig_end_i);

  always @* begin
    raw = 1'b0;
    case (mode_i)
      `PPT_MODE_PWM:   raw = pos_w < lim_w; // [RULE_03] [RULE_07] [RULE_05]
      `PPT_MODE_PULSE: raw = count < {8'h00, duty_i}; // [RULE_04] [RULE_08] [RULE_11] [RULE_12]
      `PPT_MODE_SYNC:  raw = active & (count < {8'h00, duty_i}); // [RULE_09] [RULE_12]
      `PPT_MODE_FOLLOW: raw = active & (count < {8'h00, duty_i}); // [RULE_10] [RULE_12]
      default:         raw = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      count   <= 16'h0000;
      en_q    <= 1'b0;
      armed   <= 1'b0;
      active  <= 1'b0;
      raw_q   <= 1'b0;
      out_o   <= 1'b0;
      start_o <= 1'b0;
      end_o   <= 1'b0;
    end else if (ce_i) begin
      en_q  <= enable_i;
      raw_q <= raw;
      if (!enable_i) begin
        count   <= 16'h0000;
        armed   <= 1'b0;
        active  <= 1'b0;
        out_o   <= 1'b0;
        start_o <= 1'b0;
        end_o   <= 1'b0;
      end else begin
        // Boundary fires regardless of duty, so slaves keep their period
        start_o <= rise | wrap; // [RULE_13]
        // Zero on-time still yields an end event at the boundary
        end_o   <= (raw_q & ~raw) | (start_o & ~raw); // [RULE_13]
        out_o   <= raw & (armed | (mode_i != `PPT_MODE_PULSE)); // [RULE_14]
        if (slave & trig) begin
          count  <= 16'h0000; // [RULE_09] [RULE_10]
          active <= 1'b1;
        end else if (wrap) begin
          count <= 16'h0000; // [RULE_16]
          armed <= 1'b1; // [RULE_14]
        end else if (tick_i & (count != `PPT_CNT_MAX)) begin
          count <= count + 16'h0001;
        end
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/ppt_top.v]
// Two chained PWM and pulse timers behind an AXI4-Lite register slave
//
// Functional notes
// RULE_01: Period codes 0..11 select 4 ms to 4 s.
// RULE_02: Master control: period bits 5:2, mode bit 0.
// RULE_03: Master mode 0: PWM, on-time duty*period/255.
// RULE_04: Master mode 1: pulse, duty times 100 us.
// RULE_05: Master 8-bit duty; PWM ratio duty/255.
// RULE_06: Second control: period 5:2, mode 1:0.
// RULE_07: Second mode 00: PWM on its own period.
// RULE_08: Second mode 01: pulse on its own period.
// RULE_09: Second mode 10: start at master pulse start.
// RULE_10: Second mode 11: start at master pulse end.
// RULE_11: Pulse width unit is 100 us per count.
// RULE_12: On-time beyond period keeps output on.
// RULE_13: Slave triggered even at zero master duty.
// RULE_14: Pulse mode output delayed one period after enable.
// RULE_15: Period codes 12..15 act as 4 s.
// RULE_16: Output on at period start, off after on-time.
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ppt_defs.vh"
module ppt_top #(
  parameter TICK_CYCLES = `PPT_BASE_US * `PPT_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire                     CLOCK_I,
  input  wire                     RST_N_I,
  input  wire                     CE_I,
  // AXI4-Lite write address
  input  wire                     AWVALID_I,
  output reg                      AWREADY_O,
  input  wire [`PPT_ADDR_W-1:0]   AWADDR_I,
  input  wire [2:0]               AWPROT_I,
  // AXI4-Lite write data
  input  wire                     WVALID_I,
  output reg                      WREADY_O,
  input  wire [31:0]              WDATA_I,
  input  wire [3:0]               WSTRB_I,
  // AXI4-Lite write response
  output reg                      BVALID_O,
  input  wire                     BREADY_I,
  output reg  [1:0]               BRESP_O,
  // AXI4-Lite read address
  input  wire                     ARVALID_I,
  output reg                      ARREADY_O,
  input  wire [`PPT_ADDR_W-1:0]   ARADDR_I,
  input  wire [2:0]               ARPROT_I,
  // AXI4-Lite read data
  output reg                      RVALID_O,
  input  wire                     RREADY_I,
  output reg  [31:0]              RDATA_O,
  output reg  [1:0]               RRESP_O,
  // High-voltage pin drive requests
  output reg                      HIGH_VOLTAGE_PIN_MASTER_O,
  output reg                      HIGH_VOLTAGE_PIN_SECOND_O
);

  localparam [31:0] TICK_LAST_W = TICK_CYCLES - 1;
  localparam [15:0] TICK_LAST   = TICK_LAST_W[15:0];

  // Address decode shared by the read and write paths
  function [2:0] reg_sel;
    input [`PPT_ADDR_W-1:0] a;
    begin
      if (a[`PPT_ADDR_W-1:10] != 2'h0)
        reg_sel = `PPT_SEL_NONE;
      else begin
        case (a[9:2])
          `PPT_IDX_T1_CTRL: reg_sel = `PPT_SEL_T1_CTRL;
          `PPT_IDX_T1_DUTY: reg_sel = `PPT_SEL_T1_DUTY;
          `PPT_IDX_T2_CTRL: reg_sel = `PPT_SEL_T2_CTRL;
          `PPT_IDX_T2_DUTY: reg_sel = `PPT_SEL_T2_DUTY;
          `PPT_IDX_ENABLE:  reg_sel = `PPT_SEL_ENABLE;
          `PPT_IDX_STATUS:  reg_sel = `PPT_SEL_STATUS;
          default:          reg_sel = `PPT_SEL_NONE;
        endcase
      end
    end
  endfunction

  // Registers
  reg  [7:0]              timer_one_control;
  reg  [7:0]              timer_one_duty;
  reg  [7:0]              timer_two_control;
  reg  [7:0]              timer_two_duty;
  reg  [1:0]              timer_enable;

  // Write path holding state
  reg  [`PPT_ADDR_W-1:0]  aw_addr;
  reg  [7:0]              w_data;
  reg                     w_lane;

  // Timebase
  reg  [15:0]             tick_cnt;
  reg                     tick;

  // Timer wiring
  wire                    master_out;
  wire                    master_start;
  wire                    master_end;
  wire                    second_out;

  wire [3:0] master_period_code = timer_one_control[`PPT_PC_HI:`PPT_PC_LO];
  wire       master_mode_bit    = timer_one_control[`PPT_MC1_BIT];
  wire [7:0] master_duty_value  = timer_one_duty;
  wire [3:0] second_period_code = timer_two_control[`PPT_PC_HI:`PPT_PC_LO];
  wire [1:0] second_mode_field  =
    timer_two_control[`PPT_MC2_HI:`PPT_MC2_LO];
  wire [7:0] second_duty_value  = timer_two_duty;

  wire       commit = ~AWREADY_O & ~WREADY_O & ~BVALID_O;
  wire [2:0] wsel   = reg_sel(aw_addr);
  wire [2:0] rsel   = reg_sel(ARADDR_I);

  // Free-running 100 us timebase shared by both timers
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (CE_I) begin
      if (tick_cnt >= TICK_LAST) begin
        tick_cnt <= 16'h0000;
        tick     <= 1'b1; // [RULE_11]
      end else begin
        tick_cnt <= tick_cnt + 16'h0001;
        tick     <= 1'b0;
      end
    end
  end

  // Write channel: address and data accepted in either order
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      AWREADY_O         <= 1'b1;
      WREADY_O          <= 1'b1;
      BVALID_O          <= 1'b0;
      BRESP_O           <= `PPT_RESP_OKAY;
      aw_addr           <= {`PPT_ADDR_W{1'b0}};
      w_data            <= 8'h00;
      w_lane            <= 1'b0;
      timer_one_control <= `PPT_CTRL_RST;
      timer_one_duty    <= `PPT_DUTY_RST;
      timer_two_control <= `PPT_CTRL_RST;
      timer_two_duty    <= `PPT_DUTY_RST;
      timer_enable      <= `PPT_EN_RST;
    end else if (CE_I) begin
      if (AWVALID_I & AWREADY_O) begin
        AWREADY_O <= 1'b0;
        aw_addr   <= AWADDR_I;
      end
      if (WVALID_I & WREADY_O) begin
        WREADY_O <= 1'b0;
        w_data   <= WDATA_I[7:0];
        w_lane   <= WSTRB_I[0];
      end
      if (BVALID_O & BREADY_I)
        BVALID_O <= 1'b0;
      if (commit) begin
        AWREADY_O <= 1'b1;
        WREADY_O  <= 1'b1;
        BVALID_O  <= 1'b1;
        BRESP_O   <= (wsel == `PPT_SEL_NONE) ? `PPT_RESP_SLVERR
                                             : `PPT_RESP_OKAY;
        if (w_lane) begin
          case (wsel)
            `PPT_SEL_T1_CTRL:
              timer_one_control <= w_data & `PPT_T1_CTRL_MASK; // [RULE_02]
            `PPT_SEL_T1_DUTY:
              timer_one_duty <= w_data; // [RULE_05]
            `PPT_SEL_T2_CTRL:
              timer_two_control <= w_data & `PPT_T2_CTRL_MASK; // [RULE_06]
            `PPT_SEL_T2_DUTY:
              timer_two_duty <= w_data;
            `PPT_SEL_ENABLE:
              timer_enable <= w_data[1:0];
            default:
              timer_enable <= timer_enable;
          endcase
        end
      end
    end
  end

  // Read channel: one read in flight, answer one edge after address
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h00000000;
      RRESP_O   <= `PPT_RESP_OKAY;
    end else if (CE_I) begin
      if (ARVALID_I & ARREADY_O) begin
        ARREADY_O <= 1'b0;
        RVALID_O  <= 1'b1;
        RRESP_O   <= `PPT_RESP_OKAY;
        case (rsel)
          `PPT_SEL_T1_CTRL: RDATA_O <= {24'h000000, timer_one_control};
          `PPT_SEL_T1_DUTY: RDATA_O <= {24'h000000, timer_one_duty};
          `PPT_SEL_T2_CTRL: RDATA_O <= {24'h000000, timer_two_control};
          `PPT_SEL_T2_DUTY: RDATA_O <= {24'h000000, timer_two_duty};
          `PPT_SEL_ENABLE:  RDATA_O <= {30'h00000000, timer_enable};
          `PPT_SEL_STATUS:
            RDATA_O <= {30'h00000000, second_out, master_out};
          default: begin
            RDATA_O <= 32'h00000000;
            RRESP_O <= `PPT_RESP_SLVERR;
          end
        endcase
      end else if (RVALID_O & RREADY_I) begin
        RVALID_O  <= 1'b0;
        ARREADY_O <= 1'b1;
      end
    end
  end

  // Master timer has no slave option
  ppt_timer u_master (
    .clk_i         (CLOCK_I),
    .rst_n_i       (RST_N_I),
    .ce_i          (CE_I),
    .tick_i        (tick),
    .enable_i      (timer_enable[`PPT_EN_MASTER]),
    .mode_i        ({1'b0, master_mode_bit}), // [RULE_03] [RULE_04]
    .period_code_i (master_period_code),
    .duty_i        (master_duty_value),
    .trig_start_i  (1'b0),
    .trig_end_i    (1'b0),
    .out_o         (master_out),
    .start_o       (master_start),
    .end_o         (master_end)
  );

  ppt_timer u_second (
    .clk_i         (CLOCK_I),
    .rst_n_i       (RST_N_I),
    .ce_i          (CE_I),
    .tick_i        (tick),
    .enable_i      (timer_enable[`PPT_EN_SECOND]),
    .mode_i        (second_mode_field), // [RULE_07] [RULE_08]
    .period_code_i (second_period_code),
    .duty_i        (second_duty_value),
    .trig_start_i  (master_start), // [RULE_09]
    .trig_end_i    (master_end), // [RULE_10]
    .out_o         (second_out),
    .start_o       (),
    .end_o         ()
  );

  // Pin requests retimed so the top outputs come from flops
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      HIGH_VOLTAGE_PIN_MASTER_O <= 1'b0;
      HIGH_VOLTAGE_PIN_SECOND_O <= 1'b0;
    end else if (CE_I) begin
      HIGH_VOLTAGE_PIN_MASTER_O <= master_out; // [RULE_16]
      HIGH_VOLTAGE_PIN_SECOND_O <= second_out; // [RULE_16]
    end
  end

endmodule
`default_nettype wire

// [sim/ppt_top_monitor.sv]
// Checker for the two-timer block ports, bound into the top module
`timescale 1ns/100ps
`default_nettype none
`include "ppt_defs.vh"
module ppt_top_monitor (
  // Clock and reset
  input wire logic                   CLOCK_I,
  input wire logic                   RST_N_I,
  input wire logic                   CE_I,
  // Write channels
  input wire logic                   AWVALID_I,
  input wire logic                   AWREADY_O,
  input wire logic                   WVALID_I,
  input wire logic                   WREADY_O,
  input wire logic                   BVALID_O,
  input wire logic                   BREADY_I,
  input wire logic [1:0]             BRESP_O,
  // Read channels
  input wire logic                   ARVALID_I,
  input wire logic                   ARREADY_O,
  input wire logic [`PPT_ADDR_W-1:0] ARADDR_I,
  input wire logic                   RVALID_O,
  input wire logic                   RREADY_I,
  input wire logic [31:0]            RDATA_O,
  input wire logic [1:0]             RRESP_O,
  // Pins
  input wire logic                   HIGH_VOLTAGE_PIN_MASTER_O,
  input wire logic                   HIGH_VOLTAGE_PIN_SECOND_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  logic ar_take;
  assign ar_take = ARVALID_I && ARREADY_O && CE_I;
  AST_BRESP_HOLD: assert property (BVALID_O && !BREADY_I |=> BVALID_O
    && $stable(BRESP_O)) else $error("write response dropped early");
  AST_RDATA_HOLD: assert property (RVALID_O && !RREADY_I |=> RVALID_O
    && $stable(RDATA_O)) else $error("read data dropped early");
  AST_WRITE_ANSWER: assert property (AWVALID_I && AWREADY_O && WVALID_I
    && WREADY_O && CE_I |-> ##2 BVALID_O) else $error("no write answer");
  AST_AW_BUSY: assert property (AWVALID_I && AWREADY_O && CE_I
    |=> !AWREADY_O) else $error("address slot still open");
  AST_READ_ANSWER: assert property (ar_take |=> RVALID_O)
    else $error("no read answer");
  AST_UPPER_ZERO: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_UNMAPPED: assert property (ar_take && ARADDR_I == 12'h100 |=>
    RRESP_O == 2'h2 && RDATA_O == 32'h0) else $error("unmapped read");
  AST_T1_RSV: assert property (ar_take && ARADDR_I == 12'h140 |=>
    RDATA_O[7:6] == 2'h0 && !RDATA_O[1]) else $error("reserved bits set");
  AST_T2_RSV: assert property (ar_take && ARADDR_I == 12'h148 |=>
    RDATA_O[7:6] == 2'h0) else $error("reserved bits set");
  cover property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O);
  cover property (ar_take && ARADDR_I == 12'h100);
  cover property ($rose(HIGH_VOLTAGE_PIN_MASTER_O));
  cover property ($rose(HIGH_VOLTAGE_PIN_SECOND_O));
endmodule
bind ppt_top ppt_top_monitor ppt_top_monitor_i (.*);
`default_nettype wire

// [sim/ppt_hv_load.sv]
// Load model of one high-voltage driver: measures pulse and period
`timescale 1ns/100ps
`default_nettype none
module ppt_hv_load (
  // Clock and pin
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  // Measurements in clock cycles
  output var  int   on_len,
  output var  int   per_len,
  output var  int   rise_at,
  output var  int   n_rise,
  output var  int   hi_run
);
  int   cyc;
  logic last;
  // A driver only listens, so it constrains nothing on the block
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cyc <= 0; last <= 1'b0; n_rise <= 0; hi_run <= 0;
      on_len <= 0; per_len <= 0; rise_at <= 0;
    end else begin
      cyc <= cyc + 1;
      last <= pin_i;
      hi_run <= pin_i ? hi_run + 1 : 0;
      if (pin_i && !last) begin
        per_len <= cyc - rise_at;
        rise_at <= cyc;
        n_rise <= n_rise + 1;
      end
      if (!pin_i && last) on_len <= hi_run;
    end
  end
endmodule
`default_nettype wire

// [sim/ppt_top_test.sv]
// Testbench for the two-timer block over AXI4-Lite
`timescale 1ns/100ps
`default_nettype none
module ppt_top_test;
  logic        c, rn, awv, wv, br, arv, rr;
  logic [11:0] aw, ara;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp, r;
  logic        awr, wr_, bv, arr, rv, pm, ps;
  logic [7:0]  d;
  int          on_l[2], per_l[2], rise_l[2], nr[2], hi[2];
  int          n_errors, n_tests, cyc, i, k, n0;
  int          per[3] = '{40, 80, 200};
  // Tick of 4 clocks keeps the 4 ms period at 160 clocks
  ppt_top #(.TICK_CYCLES(4)) ppt_top_i (
    .CLOCK_I(c), .RST_N_I(rn), .CE_I(1'b1),
    .AWVALID_I(awv), .AWREADY_O(awr), .AWADDR_I(aw), .AWPROT_I(3'h0),
    .WVALID_I(wv), .WREADY_O(wr_), .WDATA_I(wd), .WSTRB_I(4'h1),
    .BVALID_O(bv), .BREADY_I(br), .BRESP_O(bresp),
    .ARVALID_I(arv), .ARREADY_O(arr), .ARADDR_I(ara), .ARPROT_I(3'h0),
    .RVALID_O(rv), .RREADY_I(rr), .RDATA_O(rd), .RRESP_O(rresp),
    .HIGH_VOLTAGE_PIN_MASTER_O(pm), .HIGH_VOLTAGE_PIN_SECOND_O(ps));
  ppt_hv_load ppt_hv_load_i (.clk_i(c), .rst_n_i(rn), .pin_i(pm),
    .on_len(on_l[0]), .per_len(per_l[0]), .rise_at(rise_l[0]),
    .n_rise(nr[0]), .hi_run(hi[0]));
  ppt_hv_load ppt_hv_load_i2 (.clk_i(c), .rst_n_i(rn), .pin_i(ps),
    .on_len(on_l[1]), .per_len(per_l[1]), .rise_at(rise_l[1]),
    .n_rise(nr[1]), .hi_run(hi[1]));
  task chk(input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task wrr(input [11:0] a, input [7:0] v);
    logic ad, dd;
    @(posedge c);
    awv <= 1'b1; wv <= 1'b1; aw <= a; wd <= {24'h0, v}; br <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    // Each channel drops at the edge that saw its own ready high
    while (!(ad && dd)) begin
      @(posedge c);
      if (!ad && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr_) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!bv) @(posedge c);
    r = bresp;
    br <= 1'b0;
  endtask
  task rdr(input [11:0] a);
    @(posedge c);
    arv <= 1'b1; ara <= a; rr <= 1'b1;
    do @(posedge c); while (!arr);
    arv <= 1'b0;
    do @(posedge c); while (!rv);
    d = rd[7:0]; r = rresp;
    rr <= 1'b0;
  endtask
  // Waiting for a master rise makes both pins' stamps belong to one period
  task settle(input int n);
    repeat (n) @(posedge c);
    n0 = nr[0];
    while (nr[0] == n0) @(posedge c);
    repeat (40) @(posedge c);
  endtask
  initial begin
    c = 1'b0;
    forever #12.5 c = ~c;
  end
  always @(posedge c) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up;
    end
  end
  initial begin
    rn = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    aw = 12'h0; ara = 12'h0; wd = 32'h0;
    repeat (16) @(posedge c);
    rn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      rdr(i < 4 ? 12'h140 + 12'(4 * i) : 12'h160);
      chk(d, 8'h00);
    end
    rdr(12'h100); chk(r, 2'h2);
    wrr(12'h100, 8'h55); chk(r, 2'h2);
    wrr(12'h140, 8'hff); chk(r, 2'h0);
    rdr(12'h140); chk(d, 8'h3d);
    wrr(12'h148, 8'hff); rdr(12'h148); chk(d, 8'h3f);
    $display("test registers done");
    wrr(12'h140, 8'h00); wrr(12'h144, 8'd51); wrr(12'h160, 8'h01);
    for (i = 0; i < 3; i++) begin
      wrr(12'h140, {2'h0, 4'(i), 2'h0});
      settle(3 * per[i] * 4);
      chk(on_l[0], per[i] * 4 / 5);
      chk(per_l[0], per[i] * 4);
    end
    $display("test master pwm done");
    wrr(12'h160, 8'h00); wrr(12'h140, 8'h01); wrr(12'h144, 8'd5);
    n0 = nr[0]; k = 0;
    wrr(12'h160, 8'h01);
    while (nr[0] == n0) begin
      @(posedge c);
      k++;
    end
    chk(k >= 155 && k <= 170, 1'b1);
    settle(320);
    chk(on_l[0], 20);
    chk(per_l[0], 160);
    wrr(12'h144, 8'd255);
    repeat (400) @(posedge c);
    chk(hi[0] >= 390, 1'b1);
    $display("test master pulse done");
    wrr(12'h140, 8'h00); wrr(12'h144, 8'd51); wrr(12'h14c, 8'd3);
    wrr(12'h160, 8'h03);
    for (i = 2; i < 4; i++) begin
      wrr(12'h148, {2'h0, 4'h1, 2'(i)});
      settle(480);
      // Restart lands one or two clocks after a tick: first count is short
      chk(on_l[1], i == 2 ? 11 : 10);
      chk(per_l[1], 160);
      chk(rise_l[1] - rise_l[0], i == 2 ? 1 : 34);
    end
    wrr(12'h148, 8'h06); wrr(12'h144, 8'd0);
    n0 = nr[1];
    repeat (480) @(posedge c);
    chk(nr[1] - n0, 3);
    chk(per_l[1], 160);
    $display("test slave done");
    wrr(12'h144, 8'd51); wrr(12'h14c, 8'd128); wrr(12'h148, 8'h00);
    settle(480);
    chk(on_l[1], 84);
    chk(per_l[1], 160);
    wrr(12'h14c, 8'd2); wrr(12'h148, 8'h05);
    repeat (1000) @(posedge c);
    chk(on_l[1], 8);
    chk(per_l[1], 320);
    $display("test second autonomous done");
    wrr(12'h160, 8'h00); wrr(12'h144, 8'd1); wrr(12'h140, 8'h3c);
    wrr(12'h160, 8'h01);
    rdr(12'h164); chk(d, 8'h01);
    // Enable lands anywhere in a tick, so 157 counts span 625 to 628
    repeat (700) @(posedge c);
    chk(on_l[0] >= 625 && on_l[0] <= 628, 1'b1);
    $display("test period fallback done");
    wrap_up;
  end
endmodule
`default_nettype wire
